// ===== core/pdl_map.vh
// Operation
// RL1: Integer divide ratio spans 16 to 524287.
// RL2: Fractional average ratio limited to 20..524283.
// RL3: Divide-by-two prescale gives even ratios 40..1048566.
// RL4: Test select 10 routes divider to pin.
// RL5: Bits 5,6 gate pump up/down outputs.
// RL6: Force bits 9,10 hold pump sourcing/sinking.
// RL7: Force-mid disables pump, drives midrail source.
// RL8: Software sets delay, detector fields to recommended.
// RL9: Lock detect enable gates all lock logic.
// RL10: Hit when edge difference within window.
// RL11: Window bit picks analog or digital window.
// RL12: Speed and multiplier fields size digital window.
// RL13: Count code sets hits; code 5 = 2048.
// RL14: One miss clears flag and restarts count.
// RL15: Lock flag readable at status bit 1.
// RL16: Select 1 with bits 6,7 shows lock.
// RL17: Bit 6 clear: serial data during reads.
// RL18: Gain and offset codes are linear fields.
// RL19: Gain codes step uniformly, zero to full.
// RL20: Window opens on earlier detector edge.
// RL21: Hit targets come from configurable table.
`ifndef PDL_MAP_VH
`define PDL_MAP_VH
// Register indices; byte address is four times the index
`define PDL_IDX_DIV   5'h03
`define PDL_IDX_PDEN  5'h06
`define PDL_IDX_LD    5'h07
`define PDL_IDX_PDF   5'h08
`define PDL_IDX_CPG   5'h09
`define PDL_IDX_PDC   5'h0b
`define PDL_IDX_TST   5'h0f
`define PDL_IDX_STS   5'h12
// Reset values
`define PDL_RST_DIV   24'h000010
`define PDL_RST_PDEN  24'h000060
`define PDL_RST_ZERO  24'h000000
// Field positions
`define PDL_UP_EN     5
`define PDL_DN_EN     6
`define PDL_FRAC      7
`define PDL_F_SRC     9
`define PDL_F_SNK     10
`define PDL_DIV2      19
`define PDL_MID       11
`define PDL_LD_EN     3
`define PDL_WIN_DIG   6
`define PDL_STS_BAD   0
`define PDL_STS_LOCK  1
`define PDL_PIN_A     6
`define PDL_PIN_B     7
`define PDL_TSEL_LD   5'h01
`define PDL_TSEL_DIV  5'h0a
// Divide ratio limits
`define PDL_N_MIN_INT  19'h00010
`define PDL_N_MAX_INT  19'h7ffff
`define PDL_N_MIN_FRAC 19'h00014
`define PDL_N_MAX_FRAC 19'h7fffb
// Timing
`define PDL_CLK_NS    100
`define PDL_AWIN_NS   10
// Consecutive hit targets, code 7 first
`define PDL_HIT_TABLE {14'h2000, 14'h1000, 14'h0800, 14'h0400, \
                       14'h0200, 14'h0100, 14'h0080, 14'h0040}
`endif

// ===== core/pdl_top.v
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`include "pdl_map.vh"
`default_nettype none
module pdl_top #(
    parameter [111:0] HIT_TABLE = `PDL_HIT_TABLE
) (
    input  wire        core_clk,       // 10 MHz
    input  wire        rst_b,          // Async reset
    input  wire [6:0]  s_axi_awaddr,   // Write address
    input  wire        s_axi_awvalid,  // Write address valid
    output wire        s_axi_awready,  // Write address ready
    input  wire [31:0] s_axi_wdata,    // Write data
    input  wire [3:0]  s_axi_wstrb,    // Byte strobes
    input  wire        s_axi_wvalid,   // Write data valid
    output wire        s_axi_wready,   // Write data ready
    output reg  [1:0]  s_axi_bresp,    // Write response
    output reg         s_axi_bvalid,   // Response valid
    input  wire        s_axi_bready,   // Response ready
    input  wire [6:0]  s_axi_araddr,   // Read address
    input  wire        s_axi_arvalid,  // Read address valid
    output wire        s_axi_arready,  // Read address ready
    output reg  [31:0] s_axi_rdata,    // Read data
    output reg  [1:0]  s_axi_rresp,    // Read response
    output reg         s_axi_rvalid,   // Read valid
    input  wire        s_axi_rready,   // Read ready
    input  wire        ref_pin,        // Divided reference edge input
    input  wire        vco_pin,        // VCO input
    input  wire        serial_read,    // Serial read in progress
    input  wire        serial_data,    // Serial read data bit
    output reg         lock_or_serial_out_pin, // Shared pin
    output reg         pump_source,    // Pump up drive
    output reg         pump_sink,      // Pump down drive
    output wire        detector_force_midrail, // Midrail source on
    output wire [6:0]  pump_gain_up,   // Up gain code
    output wire [6:0]  pump_gain_dn,   // Down gain code
    output wire [6:0]  pump_offset,    // Offset code
    output wire [2:0]  pd_reset_delay, // Reset path delay
    output wire [14:0] pd_misc_ctrl    // Other detector controls
);
    localparam integer ANA_CYC_INT = `PDL_AWIN_NS / `PDL_CLK_NS;
    localparam [9:0] ANA_CYC_RAW = ANA_CYC_INT[9:0];
    localparam [9:0] ANA_CYC = (ANA_CYC_RAW == 10'h000) ? 10'h001 : ANA_CYC_RAW;
    // Byte-lane merge of a write into a 24-bit register
    function [23:0] pdl_merge;
        input [23:0] old;
        input [31:0] d;
        input [3:0]  s;
        begin
            pdl_merge = old;
            if (s[0]) pdl_merge[7:0] = d[7:0];
            if (s[1]) pdl_merge[15:8] = d[15:8];
            if (s[2]) pdl_merge[23:16] = d[23:16];
        end
    endfunction
    function pdl_mapped;
        input [4:0] idx;
        begin
            pdl_mapped = (idx == `PDL_IDX_DIV) || (idx == `PDL_IDX_PDEN) ||
                         (idx == `PDL_IDX_LD) || (idx == `PDL_IDX_PDF) ||
                         (idx == `PDL_IDX_CPG) || (idx == `PDL_IDX_PDC) ||
                         (idx == `PDL_IDX_TST) || (idx == `PDL_IDX_STS);
        end
    endfunction
    // Window length in cycles; half-period multiplier rounds up to one
    function [9:0] pdl_win_len;
        input       dig;
        input [1:0] spd;
        input [2:0] mul;
        reg   [9:0] t;
        begin
            t = ({8'h00, spd} + 10'h001) << mul;
            t = t >> 1;
            if (!dig)
                pdl_win_len = ANA_CYC;
            else if (t == 10'h000)
                pdl_win_len = 10'h001;
            else
                pdl_win_len = t;
        end
    endfunction
    reg [23:0] div_reg, pden_reg, ld_reg, pdf_reg, cpg_reg, pdc_reg, tst_reg;
    reg        aw_hold_reg, w_hold_reg;
    reg [4:0]  aw_idx_reg;
    reg [31:0] w_data_reg;
    reg [3:0]  w_strb_reg;
    reg        ref_s1_reg, ref_s2_reg, ref_s3_reg;
    reg        vco_s1_reg, vco_s2_reg, vco_s3_reg;
    reg        div2_tog_reg;
    reg [18:0] n_cnt_reg;
    reg        div_out_reg;
    reg        up_st_reg, dn_st_reg;
    reg        win_open_reg, win_first_reg;
    reg [9:0]  win_cnt_reg;
    reg [13:0] hit_cnt_reg;
    reg        lock_reg;
    // Register bus handshakes: one write and one read at a time
    assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_hold_reg && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    // Field taps
    assign detector_force_midrail = pdc_reg[`PDL_MID]; // RL7
    assign pump_gain_up   = cpg_reg[6:0];   // RL18 RL19
    assign pump_gain_dn   = cpg_reg[13:7];  // RL18 RL19
    assign pump_offset    = cpg_reg[20:14]; // RL18
    assign pd_reset_delay = pdc_reg[2:0];   // RL8
    assign pd_misc_ctrl   = pdc_reg[21:7];  // RL8

    // Effective divide ratio, clamped to the legal range of the mode
    wire        frac    = pden_reg[`PDL_FRAC];
    wire [18:0] n_req   = div_reg[18:0];
    wire [18:0] n_min   = frac ? `PDL_N_MIN_FRAC : `PDL_N_MIN_INT; // RL1 RL2
    wire [18:0] n_max   = frac ? `PDL_N_MAX_FRAC : `PDL_N_MAX_INT; // RL1 RL2
    wire        n_low   = n_req < n_min;
    wire        n_high  = n_req > n_max;
    wire [18:0] n_eff   = n_low ? n_min : (n_high ? n_max : n_req);
    wire        n_bad   = n_low || n_high;

    wire ref_rise = ref_s2_reg && !ref_s3_reg;
    wire vco_rise = vco_s2_reg && !vco_s3_reg;
    // Prescale stage passes every other VCO edge, so totals stay even
    wire div_edge = vco_rise && (!pdf_reg[`PDL_DIV2] || div2_tog_reg); // RL3
    wire div_fire = div_edge && (n_cnt_reg == n_eff - 19'h00001);      // RL1

    // Lock detector window decisions
    wire       ld_en   = ld_reg[`PDL_LD_EN]; // RL9
    wire [9:0] win_len = pdl_win_len(ld_reg[`PDL_WIN_DIG], ld_reg[11:10],
                                     ld_reg[9:7]); // RL11 RL12
    wire [13:0] target = HIT_TABLE[ld_reg[2:0] * 14 +: 14]; // RL13 RL21
    reg hit, miss, open_now, open_first;
    always @* begin
        hit = 1'b0;
        miss = 1'b0;
        open_now = 1'b0;
        open_first = 1'b0;
        if (!win_open_reg) begin
            if (ref_rise && div_fire) begin
                hit = 1'b1;
            end else if (ref_rise || div_fire) begin
                open_now = 1'b1; // RL20
                open_first = div_fire;
            end
        end else if (win_first_reg ? ref_rise : div_fire) begin
            hit = 1'b1; // RL10
        end else if (win_first_reg ? div_fire : ref_rise) begin
            miss = 1'b1;
            open_now = 1'b1;
            open_first = win_first_reg;
        end else if (win_cnt_reg >= win_len) begin
            miss = 1'b1; // RL10
        end
    end

    // Pump drive: forcing wins over gating, midrail overrides both
    wire src_next = !detector_force_midrail &&
                    (pdf_reg[`PDL_F_SRC] || (pden_reg[`PDL_UP_EN] && up_st_reg));
    wire snk_next = !detector_force_midrail &&
                    (pdf_reg[`PDL_F_SNK] || (pden_reg[`PDL_DN_EN] && dn_st_reg));

    // Shared pin selection
    reg pin_next;
    always @* begin
        pin_next = 1'b0;
        if (tst_reg[4:0] == `PDL_TSEL_DIV)
            pin_next = div_out_reg; // RL4
        else if (tst_reg[4:0] == `PDL_TSEL_LD) begin
            if (!tst_reg[`PDL_PIN_A])
                pin_next = serial_read ? serial_data : lock_reg; // RL17
            else if (tst_reg[`PDL_PIN_B])
                pin_next = lock_reg; // RL16
        end
    end

    // Read mux; unmapped indices and unused status bits read zero
    reg [23:0] rd_val;
    always @* begin
        case (s_axi_araddr[6:2])
            `PDL_IDX_DIV:  rd_val = div_reg;
            `PDL_IDX_PDEN: rd_val = pden_reg;
            `PDL_IDX_LD:   rd_val = ld_reg;
            `PDL_IDX_PDF:  rd_val = pdf_reg;
            `PDL_IDX_CPG:  rd_val = cpg_reg;
            `PDL_IDX_PDC:  rd_val = pdc_reg;
            `PDL_IDX_TST:  rd_val = tst_reg;
            `PDL_IDX_STS: begin
                rd_val = `PDL_RST_ZERO;
                rd_val[`PDL_STS_LOCK] = lock_reg; // RL15
                rd_val[`PDL_STS_BAD] = n_bad;
            end
            default:       rd_val = `PDL_RST_ZERO;
        endcase
    end

    // Register bus slave
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            aw_idx_reg <= 5'h00;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= 2'h0;
            s_axi_rdata <= 32'h00000000;
            div_reg <= `PDL_RST_DIV;
            pden_reg <= `PDL_RST_PDEN;
            ld_reg <= `PDL_RST_ZERO;
            pdf_reg <= `PDL_RST_ZERO;
            cpg_reg <= `PDL_RST_ZERO;
            pdc_reg <= `PDL_RST_ZERO;
            tst_reg <= `PDL_RST_ZERO;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_reg <= 1'b1;
                aw_idx_reg <= s_axi_awaddr[6:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (aw_hold_reg && w_hold_reg) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= pdl_mapped(aw_idx_reg) ? 2'h0 : 2'h2;
                case (aw_idx_reg)
                    `PDL_IDX_DIV:  div_reg <= pdl_merge(div_reg, w_data_reg, w_strb_reg);
                    `PDL_IDX_PDEN: pden_reg <= pdl_merge(pden_reg, w_data_reg, w_strb_reg);
                    `PDL_IDX_LD:   ld_reg <= pdl_merge(ld_reg, w_data_reg, w_strb_reg);
                    `PDL_IDX_PDF:  pdf_reg <= pdl_merge(pdf_reg, w_data_reg, w_strb_reg);
                    `PDL_IDX_CPG:  cpg_reg <= pdl_merge(cpg_reg, w_data_reg, w_strb_reg);
                    `PDL_IDX_PDC:  pdc_reg <= pdl_merge(pdc_reg, w_data_reg, w_strb_reg);
                    `PDL_IDX_TST:  tst_reg <= pdl_merge(tst_reg, w_data_reg, w_strb_reg);
                    default: begin
                    end
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {8'h00, rd_val};
                s_axi_rresp <= pdl_mapped(s_axi_araddr[6:2]) ? 2'h0 : 2'h2;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Pin synchronisers; edges are taken from the second and third stages
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ref_s1_reg <= 1'b0;
            ref_s2_reg <= 1'b0;
            ref_s3_reg <= 1'b0;
            vco_s1_reg <= 1'b0;
            vco_s2_reg <= 1'b0;
            vco_s3_reg <= 1'b0;
        end else begin
            ref_s1_reg <= ref_pin;
            ref_s2_reg <= ref_s1_reg;
            ref_s3_reg <= ref_s2_reg;
            vco_s1_reg <= vco_pin;
            vco_s2_reg <= vco_s1_reg;
            vco_s3_reg <= vco_s2_reg;
        end
    end

    // Divider and phase detector state
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            div2_tog_reg <= 1'b0;
            n_cnt_reg <= 19'h00000;
            div_out_reg <= 1'b0;
            up_st_reg <= 1'b0;
            dn_st_reg <= 1'b0;
            pump_source <= 1'b0;
            pump_sink <= 1'b0;
            lock_or_serial_out_pin <= 1'b0;
        end else begin
            if (vco_rise)
                div2_tog_reg <= !div2_tog_reg;
            if (div_fire)
                n_cnt_reg <= 19'h00000;
            else if (div_edge)
                n_cnt_reg <= (n_cnt_reg >= n_eff) ? 19'h00000 : n_cnt_reg + 19'h00001;
            div_out_reg <= n_cnt_reg < (n_eff >> 1);
            // Both edges seen: reset the detector, as a tri-state PFD does
            if ((ref_rise || up_st_reg) && (div_fire || dn_st_reg)) begin
                up_st_reg <= 1'b0;
                dn_st_reg <= 1'b0;
            end else begin
                up_st_reg <= up_st_reg || ref_rise;
                dn_st_reg <= dn_st_reg || div_fire;
            end
            pump_source <= src_next; // RL5 RL6 RL7
            pump_sink <= snk_next;   // RL5 RL6 RL7
            lock_or_serial_out_pin <= pin_next;
        end
    end

    // Window lock detector
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            win_open_reg <= 1'b0;
            win_first_reg <= 1'b0;
            win_cnt_reg <= 10'h000;
            hit_cnt_reg <= 14'h0000;
            lock_reg <= 1'b0;
        end else if (!ld_en) begin
            win_open_reg <= 1'b0; // RL9
            win_cnt_reg <= 10'h000;
            hit_cnt_reg <= 14'h0000;
            lock_reg <= 1'b0;
        end else begin
            if (open_now) begin
                win_open_reg <= 1'b1;
                win_first_reg <= open_first;
                win_cnt_reg <= 10'h001;
            end else if (hit || miss) begin
                win_open_reg <= 1'b0;
                win_cnt_reg <= 10'h000;
            end else if (win_open_reg) begin
                win_cnt_reg <= win_cnt_reg + 10'h001;
            end
            if (miss) begin
                hit_cnt_reg <= 14'h0000; // RL14
                lock_reg <= 1'b0;        // RL14
            end else if (hit) begin
                if (hit_cnt_reg >= target - 14'h0001)
                    lock_reg <= 1'b1;    // RL13
                else
                    hit_cnt_reg <= hit_cnt_reg + 14'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// ===== verif/pdl_vco_ref_model.sv
`default_nettype none
module pdl_vco_ref_model (
    input  wire logic ref_on,  // Reference edges enabled
    output var  logic vco_pin, // Free-running VCO
    output var  logic ref_pin  // Divided reference pulse
);
    timeunit 1ns;
    timeprecision 100ps;
    // VCO runs free; 400 ns period keeps both levels two clocks wide
    initial begin
        vco_pin = 1'b0;
        forever #200 vco_pin = ~vco_pin;
    end
    // One reference pulse per 16 VCO cycles, phase kept off the clock edges
    initial begin
        ref_pin = 1'b0;
        #37;
        forever begin
            ref_pin = ref_on;
            #800 ref_pin = 1'b0;
            #5600;
        end
    end
endmodule
`default_nettype wire

// ===== verif/pdl_top_monitor.sv
`default_nettype none
module pdl_check_monitor #(
    parameter [111:0] HIT_TABLE = 112'h0 // Hit targets of the block
) (
    input wire logic        core_clk,               // Clock
    input wire logic        rst_b,                  // Reset
    input wire logic        s_axi_awvalid,          // Aw valid
    input wire logic        s_axi_awready,          // Aw ready
    input wire logic        s_axi_wvalid,           // W valid
    input wire logic        s_axi_wready,           // W ready
    input wire logic        s_axi_bvalid,           // B valid
    input wire logic        s_axi_bready,           // B ready
    input wire logic [1:0]  s_axi_bresp,            // B response
    input wire logic        s_axi_arvalid,          // Ar valid
    input wire logic        s_axi_arready,          // Ar ready
    input wire logic [31:0] s_axi_rdata,            // Read data
    input wire logic [1:0]  s_axi_rresp,            // R response
    input wire logic        s_axi_rvalid,           // R valid
    input wire logic        s_axi_rready,           // R ready
    input wire logic        pump_source,            // Pump up
    input wire logic        pump_sink,              // Pump down
    input wire logic        detector_force_midrail, // Midrail
    input wire logic        lock_or_serial_out_pin  // Shared pin
);
    logic w_take;
    logic ar_take;
    // Either write half taken; the response must trail one of them
    assign w_take = (s_axi_awvalid && s_axi_awready) || (s_axi_wvalid && s_axi_wready);
    assign ar_take = s_axi_arvalid && s_axi_arready;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);
    AST_RST_QUIET: assert property (disable iff (1'b0) !rst_b |-> s_axi_awready && s_axi_wready
        && s_axi_arready && !s_axi_bvalid && !s_axi_rvalid && !pump_source && !pump_sink)
        else $error("outputs not idle in reset");
    AST_AR_OPEN: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("read address ready wrong");
    AST_B_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    AST_B_CAUSE: assert property ($rose(s_axi_bvalid) |-> $past(w_take, 2))
        else $error("write response without a write");
    AST_B_HOLD: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    AST_R_CAUSE: assert property ($rose(s_axi_rvalid) |-> $past(ar_take))
        else $error("read data without a request");
    AST_R_DROP: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data repeated");
    AST_R_WORD: assert property (s_axi_rvalid |-> s_axi_rdata[31:24] == 8'h00 &&
        !s_axi_rresp[0]) else $error("read word malformed");
    AST_R_ERR0: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0)
        else $error("error read returned data");
    AST_MID_QUIET: assert property (detector_force_midrail [*2] |-> !pump_source && !pump_sink)
        else $error("pump active under midrail");
    // Main scenarios reached
    cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'b10);
    cover property ($rose(lock_or_serial_out_pin));
    cover property (pump_source ##1 pump_sink);
endmodule
bind pdl_top pdl_check_monitor #(.HIT_TABLE(HIT_TABLE)) u_pdl_check (.*);
`default_nettype wire

// ===== verif/tb_pdl_top.sv
`include "pdl_map.vh"
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_pdl_top;
    timeunit 1ns;
    timeprecision 100ps;
    // Code 5 gets a short target; others unreachable, so a wrong index never locks
    localparam [111:0] TBL = {14'h3fff, 14'h3fff, 14'h0004, {5{14'h3fff}}};
    localparam [31:0]  PDC_RECOM = 32'h0; // Recommended detector setup, plain default
    logic        core_clk, rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, ref_pin, vco_pin, serial_read, serial_data, ref_on;
    logic        lock_or_serial_out_pin, pump_source, pump_sink, detector_force_midrail;
    logic [6:0]  s_axi_awaddr, s_axi_araddr, pump_gain_up, pump_gain_dn, pump_offset;
    logic [31:0] s_axi_wdata, s_axi_rdata, rnd;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [2:0]  pd_reset_delay;
    logic [14:0] pd_misc_ctrl;
    logic [33:0] exp_q[$], exp_v;
    int          n_errors, num_checks, n_pin, n_rise, n_pmp;
    logic [18:0] lim_n[6] = '{19'h0000f, 19'h00010, 19'h00013, 19'h00014, 19'h7fffb, 19'h7fffc};
    logic        lim_f[6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
    logic        lim_b[6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};

    pdl_top #(.HIT_TABLE(TBL)) i_pdl_top (.*);
    pdl_vco_ref_model i_pdl_vco_ref_model (.*);

    // 10 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // Handshakes sampled at the falling edge, as they stand at the next rising one
    task automatic wr(input logic [4:0] i, input logic [31:0] d, input logic [1:0] r);
        logic a_hit, w_hit, b_hit;
        @(posedge core_clk);
        exp_q.push_back({r, 32'h0});
        s_axi_awaddr <= {i, 2'b00};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(negedge core_clk);
            a_hit = s_axi_awvalid && s_axi_awready;
            w_hit = s_axi_wvalid && s_axi_wready;
            b_hit = s_axi_bvalid && s_axi_bready;
            @(posedge core_clk);
            if (a_hit) s_axi_awvalid <= 1'b0;
            if (w_hit) s_axi_wvalid <= 1'b0;
        end while (!b_hit);
    endtask
    task automatic rd(input logic [4:0] i, input logic [31:0] d, input logic [1:0] r);
        logic a_hit, r_hit;
        @(posedge core_clk);
        exp_q.push_back({r, d});
        s_axi_araddr <= {i, 2'b00};
        s_axi_arvalid <= 1'b1;
        do begin
            @(negedge core_clk);
            a_hit = s_axi_arvalid && s_axi_arready;
            r_hit = s_axi_rvalid && s_axi_rready;
            @(posedge core_clk);
            if (a_hit) s_axi_arvalid <= 1'b0;
        end while (!r_hit);
    endtask
    // Bounded wait for a pin level
    task automatic pin_is(input logic v, input int lim);
        int k;
        k = 0;
        do begin
            @(negedge core_clk);
            k++;
        end while (lock_or_serial_out_pin !== v && k < lim);
        `CHK(lock_or_serial_out_pin, v)
    endtask
    // High cycles and rises of the pin, pump activity, over n cycles
    task automatic watch(input int n);
        logic prev;
        n_pin = 0;
        n_rise = 0;
        n_pmp = 0;
        @(negedge core_clk);
        prev = lock_or_serial_out_pin;
        repeat (n) begin
            @(negedge core_clk);
            n_pin += lock_or_serial_out_pin;
            n_rise += lock_or_serial_out_pin && !prev;
            n_pmp += pump_source || pump_sink;
            prev = lock_or_serial_out_pin;
        end
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Oldest noted answer against each bus response; popped once so a print cannot eat a note
    always @(posedge core_clk) begin
        if (s_axi_bvalid && s_axi_bready) begin
            exp_v = exp_q.pop_front();
            `CHK({s_axi_bresp, 32'h0}, exp_v)
        end
        if (s_axi_rvalid && s_axi_rready) begin
            exp_v = exp_q.pop_front();
            `CHK({s_axi_rresp, s_axi_rdata}, exp_v)
        end
    end
    // Hang guard, well past the expected few thousand cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        end_sim();
    end
    initial begin
        void'($urandom(32'h42a551ba));
        n_errors = 0;
        num_checks = 0;
        {rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, ref_on} <= 5'h00;
        {serial_read, serial_data, s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= 48'h0;
        {s_axi_wstrb, s_axi_bready, s_axi_rready} <= 6'h3f; // Responses always accepted
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        rd(`PDL_IDX_DIV, 32'h10, 2'b00);
        rd(`PDL_IDX_PDEN, 32'h60, 2'b00);
        rd(5'h01, 32'h0, 2'b10);
        wr(5'h01, 32'h1, 2'b10);
        wr(`PDL_IDX_STS, 32'hff, 2'b00);
        for (int k = 0; k < 6; k++) begin
            wr(`PDL_IDX_PDEN, {24'h0, lim_f[k], 7'h60}, 2'b00);
            wr(`PDL_IDX_DIV, {13'h0, lim_n[k]}, 2'b00);
            rd(`PDL_IDX_STS, {31'h0, lim_b[k]}, 2'b00);
        end
        wr(`PDL_IDX_PDEN, 32'h60, 2'b00);
        wr(`PDL_IDX_DIV, 32'h10, 2'b00);
        repeat (3) begin
            rnd = $urandom;
            wr(`PDL_IDX_CPG, rnd, 2'b00);
            @(negedge core_clk);
            `CHK({pump_offset, pump_gain_dn, pump_gain_up}, rnd[20:0])
        end
        rnd = $urandom | 32'h800;
        wr(`PDL_IDX_PDC, rnd, 2'b00);
        @(negedge core_clk);
        `CHK({detector_force_midrail, pump_source, pump_sink}, 3'b100)
        `CHK({pd_misc_ctrl, pd_reset_delay}, {rnd[21:7], rnd[2:0]})
        wr(`PDL_IDX_PDC, PDC_RECOM, 2'b00);
        wr(`PDL_IDX_PDF, 32'h200, 2'b00);
        @(negedge core_clk);
        `CHK(pump_source, 1'b1)
        wr(`PDL_IDX_PDF, 32'h400, 2'b00);
        @(negedge core_clk);
        `CHK(pump_sink, 1'b1)
        wr(`PDL_IDX_PDF, 32'h0, 2'b00);
        wr(`PDL_IDX_TST, 32'h0a, 2'b00);
        watch(256);
        `CHK({n_rise, n_pin}, {32'd4, 32'd128})
        wr(`PDL_IDX_PDF, 32'h80000, 2'b00);
        watch(256);
        `CHK(n_rise, 2)
        wr(`PDL_IDX_PDF, 32'h0, 2'b00);
        ref_on <= 1'b1;
        wr(`PDL_IDX_PDEN, 32'h0, 2'b00);
        watch(256);
        `CHK(n_pmp, 0)
        wr(`PDL_IDX_PDEN, 32'h60, 2'b00);
        watch(256);
        `CHK(n_pmp > 0, 1'b1)
        wr(`PDL_IDX_TST, 32'hc1, 2'b00);
        wr(`PDL_IDX_LD, 32'hfcd, 2'b00); // Code 5, 256-cycle digital window
        watch(150);
        `CHK(n_pin, 0)
        pin_is(1'b1, 400);
        rd(`PDL_IDX_STS, 32'h2, 2'b00);
        ref_on <= 1'b0;
        pin_is(1'b0, 300);
        rd(`PDL_IDX_STS, 32'h0, 2'b00);
        ref_on <= 1'b1;
        watch(150);
        `CHK(n_pin, 0)
        pin_is(1'b1, 400);
        wr(`PDL_IDX_TST, 32'h01, 2'b00);
        repeat (6) begin
            rnd = $urandom;
            serial_read <= 1'b1;
            serial_data <= rnd[0];
            @(posedge core_clk);
            @(negedge core_clk);
            `CHK(lock_or_serial_out_pin, rnd[0])
            @(posedge core_clk);
        end
        serial_read <= 1'b0;
        pin_is(1'b1, 5);
        wr(`PDL_IDX_LD, 32'hfc5, 2'b00);
        pin_is(1'b0, 5);
        rd(`PDL_IDX_STS, 32'h0, 2'b00);
        end_sim();
    end
endmodule
`default_nettype wire
